// [hw/kse_pkg.sv]
// constants and types for the keyboard scan encoder
package kse_pkg;
	localparam int unsigned CODE_W      = 7;
	localparam int unsigned ROW_W       = 4;
	localparam int unsigned ADDR_W      = 8;
	localparam int unsigned DATA_W      = 32;
	localparam int unsigned MSG_DEPTH   = 32;
	localparam int unsigned MSG_IDX_W   = 5;
	localparam int unsigned MSG_LEN_W   = 6;
	localparam int unsigned BNC_CNT_W   = 3;
	// row-rate ticks in one debounce period
	localparam logic [2:0]  BNC_TICKS   = 3'h5;
	// line-rate pulses in one repeat cycle
	localparam logic [2:0]  RPT_PULSES  = 3'h5;

	// code bit positions (scan bits 1..7 held in bits 0..6)
	localparam int unsigned BIT5_POS    = 4;
	localparam int unsigned BIT6_POS    = 5;
	localparam int unsigned BIT7_POS    = 6;
	localparam logic [2:0]  COL_TWO     = 3'h2;
	localparam logic [2:0]  COL_THREE   = 3'h3;
	localparam logic [3:0]  ROW_ZERO    = 4'h0;

	// register map, byte addresses
	localparam logic [7:0]  REG_CONTROL = 8'h00;
	localparam logic [7:0]  REG_STATUS  = 8'h04;
	localparam logic [7:0]  REG_MSG_LEN = 8'h08;
	localparam logic [7:0]  REG_MSG_BASE = 8'h80;
	localparam logic [1:0]  MSG_WSEL    = 2'h2;

	// control fields
	localparam int unsigned CTL_HOLD_EN = 0;
	localparam int unsigned CTL_ANS_EN  = 1;
	localparam logic [1:0]  CTL_RESET   = 2'h0;
	localparam logic [5:0]  MSG_LEN_RESET = 6'h00;

	// status fields
	localparam int unsigned ST_ENABLED  = 0;
	localparam int unsigned ST_DONE     = 1;
	localparam int unsigned ST_ANS_BUSY = 2;
	localparam int unsigned ST_MATCH    = 3;
	localparam int unsigned ST_CODE_LSB = 8;

	typedef enum logic [1:0] {
		ANS_IDLE,
		ANS_WAIT,
		ANS_SEND
	} kse_ans_state_t;
endpackage

// [hw/kse_bounce_if.sv]
// link between the encoder and its debounce timer
interface kse_bounce_if;
	logic start;
	logic keyHeld;
	logic repeatKey;
	logic done;
	logic repeatFire;

	modport enc
	(
		output start,
		output keyHeld,
		output repeatKey,
		input  done,
		input  repeatFire
	);
	modport bnc
	(
		input  start,
		input  keyHeld,
		input  repeatKey,
		output done,
		output repeatFire
	);
endinterface

// [hw/kse_debounce.sv]
// debounce and auto-repeat timer
module kse_debounce
	import kse_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic rst_b,
	input  wire logic row_rate_tick,
	input  wire logic line_rate_pulse,
	kse_bounce_if.bnc bnc
);
	logic [BNC_CNT_W-1:0] cnt_q;
	logic [BNC_CNT_W-1:0] cnt_d;
	logic                 done_q;
	logic                 done_d;
	logic                 fire_q;
	logic                 fire_d;

	always_comb
	begin
		cnt_d  = cnt_q;
		done_d = done_q;
		fire_d = 1'b0;
		if (bnc.start)
		begin
			cnt_d  = '0;
			done_d = 1'b0;
		end
		else if (!done_q && row_rate_tick)
		begin
			if (cnt_q == BNC_TICKS - 3'h1)
			begin
				cnt_d  = '0;
				done_d = 1'b1;
			end
			else
				cnt_d = cnt_q + 3'h1;
		end
		else if (done_q && bnc.keyHeld && bnc.repeatKey && line_rate_pulse)
		begin
			if (cnt_q == RPT_PULSES - 3'h1)
			begin
				cnt_d  = '0;
				fire_d = 1'b1;
			end
			else
				cnt_d = cnt_q + 3'h1;
		end
		else if (done_q && !(bnc.keyHeld && bnc.repeatKey))
			cnt_d = '0;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_q  <= '0;
			done_q <= 1'b1;
			fire_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			done_q <= done_d;
			fire_q <= fire_d;
		end
	end

	assign bnc.done       = done_q;
	assign bnc.repeatFire = fire_q;
endmodule

// [hw/kse_code_modifier.sv]
// control, shift and upper-case code modifier
module kse_code_modifier
	import kse_pkg::*;
(
	input  wire logic [CODE_W-1:0] rawCode,
	input  wire logic              ctrlKey,
	input  wire logic              shiftKey,
	input  wire logic              upperCaseKey,
	output logic      [CODE_W-1:0] modCode
);
	logic [2:0]       column;
	logic [ROW_W-1:0] row;
	logic             lowerAlpha;
	logic             upper_column_shift_allow;
	logic             case_column_swap;
	logic             column_three_detect;
	logic             column_two_detect;
	logic             modified_code_bit5;
	logic             modified_code_bit6;
	logic             modified_code_bit7;

	always_comb
	begin
		column = rawCode[CODE_W-1:ROW_W];
		row    = rawCode[ROW_W-1:0];
		lowerAlpha = upperCaseKey && rawCode[BIT7_POS] && rawCode[BIT6_POS];
		upper_column_shift_allow = rawCode[BIT7_POS] && !lowerAlpha;
		case_column_swap = lowerAlpha
			|| (shiftKey && upper_column_shift_allow);
		column_two_detect   = (column == COL_TWO);
		column_three_detect = (column == COL_THREE);
		modified_code_bit5 = rawCode[BIT5_POS]
			^ (shiftKey && column_three_detect && row != ROW_ZERO);
		modified_code_bit6 = rawCode[BIT6_POS] ^ case_column_swap;
		modified_code_bit7 = rawCode[BIT7_POS];
		if (ctrlKey)
		begin
			modified_code_bit6 = 1'b0;
			modified_code_bit7 = 1'b0;
		end
		modCode = {modified_code_bit7, modified_code_bit6,
			modified_code_bit5, row};
	end
endmodule

// [hw/kse_keyboard_encoder.sv]
// keyboard scan encoder top level
//
// Added by the designer: strobed register access and the address map.
module kse_keyboard_encoder
	import kse_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              rst_b,
	input  wire logic              char_rate_tick,
	input  wire logic              row_rate_tick,
	input  wire logic              line_rate_pulse,
	input  wire logic              keyMatch_n,
	input  wire logic              repeat_key,
	input  wire logic              ctrlKey,
	input  wire logic              shiftKey,
	input  wire logic              upperCaseKey,
	input  wire logic              breakKey,
	input  wire logic              clearKey,
	input  wire logic              identify_key,
	input  wire logic              tx_holding_empty,
	input  wire logic              transmitting,
	input  wire logic              secondaryMode,
	input  wire logic              command_execute_window,
	input  wire logic              lockCmd,
	input  wire logic              unlockCmd,
	input  wire logic              enqCmd,
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [DATA_W-1:0] regWrData,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [DATA_W-1:0] regRdData,
	output logic      [CODE_W-1:0] scan_code_bits,
	output logic                   scan_step_clock,
	output logic      [CODE_W-1:0] txCode,
	output logic                   keystrokeStrobe,
	output logic                   primaryForceSpace,
	output logic                   secondaryForceMark,
	output logic                   clear_request,
	output logic                   keys_enabled_flag
);
	////////////////////////////////////////////////////////////////////////
	// sampled key inputs
	logic              matchHeld_q;
	logic              matchHeld_d;
	logic              repeatHeld_q;
	logic              repeatHeld_d;
	logic              keysPrev_q;
	logic              keysPrev_d;

	always_comb
	begin
		matchHeld_d  = !keyMatch_n;
		repeatHeld_d = repeat_key;
		keysPrev_d   = matchHeld_q;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			matchHeld_q  <= 1'b0;
			repeatHeld_q <= 1'b0;
			keysPrev_q   <= 1'b0;
		end
		else
		begin
			matchHeld_q  <= matchHeld_d;
			repeatHeld_q <= repeatHeld_d;
			keysPrev_q   <= keysPrev_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// scan counter
	logic [CODE_W-1:0] scan_q;
	logic [CODE_W-1:0] scan_d;

	always_comb
	begin
		scan_step_clock = char_rate_tick && keyMatch_n;
		scan_d = scan_q;
		if (scan_step_clock)
			scan_d = scan_q + 7'h01;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			scan_q <= '0;
		else
			scan_q <= scan_d;
	end

	assign scan_code_bits = scan_q;

	////////////////////////////////////////////////////////////////////////
	// modifiers and debounce
	logic [CODE_W-1:0] modCode;

	kse_code_modifier u_mod
	(
		.rawCode      (scan_q),
		.ctrlKey      (ctrlKey),
		.shiftKey     (shiftKey),
		.upperCaseKey (upperCaseKey),
		.modCode      (modCode)
	);

	kse_bounce_if bif ();

	kse_debounce u_bnc
	(
		.core_clk        (core_clk),
		.rst_b           (rst_b),
		.row_rate_tick   (row_rate_tick),
		.line_rate_pulse (line_rate_pulse),
		.bnc             (bif.bnc)
	);

	logic newMatch;

	always_comb
	begin
		newMatch      = matchHeld_q && !keysPrev_q && bif.done;
		bif.start     = newMatch;
		bif.keyHeld   = matchHeld_q;
		bif.repeatKey = repeatHeld_q;
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	logic [1:0]           ctl_q;
	logic [1:0]           ctl_d;
	logic [MSG_LEN_W-1:0] msgLen_q;
	logic [MSG_LEN_W-1:0] msgLen_d;
	logic [CODE_W-1:0]    msg_q [MSG_DEPTH];
	logic [CODE_W-1:0]    msg_d [MSG_DEPTH];
	logic [DATA_W-1:0]    rd_q;
	logic [DATA_W-1:0]    rd_d;
	logic                 msgHit;
	logic [MSG_IDX_W-1:0] msgWrIdx;
	logic                 ansBusy;

	always_comb
	begin
		ctl_d    = ctl_q;
		msgLen_d = msgLen_q;
		msg_d    = msg_q;
		rd_d     = '0;
		msgHit   = (regAddr[ADDR_W-1] == 1'b1);
		msgWrIdx = regAddr[MSG_IDX_W+1:MSG_WSEL];
		if (regWr)
		begin
			if (msgHit)
				msg_d[msgWrIdx] = regWrData[CODE_W-1:0];
			else if (regAddr == REG_CONTROL)
				ctl_d = regWrData[1:0];
			else if (regAddr == REG_MSG_LEN)
				msgLen_d = regWrData[MSG_LEN_W-1:0];
		end
		if (regRd)
		begin
			if (msgHit)
				rd_d[CODE_W-1:0] = msg_q[msgWrIdx];
			else if (regAddr == REG_CONTROL)
				rd_d[1:0] = ctl_q;
			else if (regAddr == REG_MSG_LEN)
				rd_d[MSG_LEN_W-1:0] = msgLen_q;
			else if (regAddr == REG_STATUS)
			begin
				rd_d[ST_ENABLED]  = keys_enabled_flag;
				rd_d[ST_DONE]     = bif.done;
				rd_d[ST_ANS_BUSY] = ansBusy;
				rd_d[ST_MATCH]    = matchHeld_q;
				rd_d[ST_CODE_LSB +: CODE_W] = scan_q;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctl_q    <= CTL_RESET;
			msgLen_q <= MSG_LEN_RESET;
			msg_q    <= '{default: '0};
			rd_q     <= '0;
		end
		else
		begin
			ctl_q    <= ctl_d;
			msgLen_q <= msgLen_d;
			msg_q    <= msg_d;
			rd_q     <= rd_d;
		end
	end

	assign regRdData = rd_q;

	////////////////////////////////////////////////////////////////////////
	// keyboard lock
	logic enabled_q;
	logic enabled_d;

	always_comb
	begin
		clear_request = clearKey && shiftKey;
		enabled_d = enabled_q;
		if (command_execute_window && lockCmd)
			enabled_d = 1'b0;
		if (clear_request || (command_execute_window && unlockCmd))
			enabled_d = 1'b1;
		if (ctl_q[CTL_HOLD_EN])
			enabled_d = 1'b1;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			enabled_q <= 1'b1;
		else
			enabled_q <= enabled_d;
	end

	assign keys_enabled_flag = enabled_q;

	////////////////////////////////////////////////////////////////////////
	// break lines
	always_comb
	begin
		primaryForceSpace  = breakKey && transmitting;
		secondaryForceMark = breakKey && !transmitting && secondaryMode;
	end

	////////////////////////////////////////////////////////////////////////
	// keystroke, repeat and answer-back output
	kse_ans_state_t       ans_q;
	kse_ans_state_t       ans_d;
	logic [MSG_LEN_W-1:0] ansIdx_q;
	logic [MSG_LEN_W-1:0] ansIdx_d;
	logic                 rptPend_q;
	logic                 rptPend_d;
	logic [CODE_W-1:0]    txCode_q;
	logic [CODE_W-1:0]    txCode_d;
	logic                 strobe_q;
	logic                 strobe_d;
	logic                 ansTrigger;

	always_comb
	begin
		ans_d      = ans_q;
		ansIdx_d   = ansIdx_q;
		rptPend_d  = rptPend_q;
		txCode_d   = txCode_q;
		strobe_d   = 1'b0;
		ansBusy    = (ans_q != ANS_IDLE);
		ansTrigger = ctl_q[CTL_ANS_EN] && msgLen_q != MSG_LEN_RESET
			&& (identify_key || (command_execute_window && enqCmd));
		if (!matchHeld_q)
			rptPend_d = 1'b0;
		if (bif.repeatFire)
			rptPend_d = 1'b1;
		case (ans_q)
			ANS_IDLE:
			begin
				ansIdx_d = '0;
				if (ansTrigger)
					ans_d = ANS_WAIT;
				else if (newMatch && enabled_q)
				begin
					txCode_d = modCode;
					strobe_d = 1'b1;
				end
				else if (rptPend_q && tx_holding_empty && matchHeld_q)
				begin
					rptPend_d = bif.repeatFire;
					if (enabled_q)
					begin
						txCode_d = modCode;
						strobe_d = 1'b1;
					end
				end
			end
			ANS_WAIT:
			begin
				if (tx_holding_empty && !strobe_q)
					ans_d = ANS_SEND;
			end
			ANS_SEND:
			begin
				txCode_d = msg_q[ansIdx_q[MSG_IDX_W-1:0]];
				strobe_d = 1'b1;
				ansIdx_d = ansIdx_q + 6'h01;
				if (ansIdx_q + 6'h01 >= msgLen_q)
					ans_d = ANS_IDLE;
				else
					ans_d = ANS_WAIT;
			end
			default:
				ans_d = ANS_IDLE;
		endcase
		if (clear_request)
			ans_d = ANS_IDLE;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ans_q     <= ANS_IDLE;
			ansIdx_q  <= '0;
			rptPend_q <= 1'b0;
			txCode_q  <= '0;
			strobe_q  <= 1'b0;
		end
		else
		begin
			ans_q     <= ans_d;
			ansIdx_q  <= ansIdx_d;
			rptPend_q <= rptPend_d;
			txCode_q  <= txCode_d;
			strobe_q  <= strobe_d;
		end
	end

	assign txCode          = txCode_q;
	assign keystrokeStrobe = strobe_q;
endmodule

// [sim/kse_key_array.sv]
// key switch array model: match goes low while scan meets the held key
module kse_key_array
	import kse_pkg::*;
(
	input  wire logic [CODE_W-1:0] scan_code_bits,
	input  wire logic              keyDown,
	input  wire logic [CODE_W-1:0] keyCode,
	output logic                   keyMatch_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// match only while held and the code lines agree
	assign keyMatch_n = !(keyDown && scan_code_bits == keyCode);
endmodule

// [sim/kse_checker_assertions.sv]
// port-level assertions for the keyboard scan encoder
module kse_checker
	import kse_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              rst_b,
	input  wire logic              char_rate_tick,
	input  wire logic              keyMatch_n,
	input  wire logic              breakKey,
	input  wire logic              transmitting,
	input  wire logic              secondaryMode,
	input  wire logic              clearKey,
	input  wire logic              shiftKey,
	input  wire logic              regRd,
	input  wire logic [DATA_W-1:0] regRdData,
	input  wire logic [CODE_W-1:0] scan_code_bits,
	input  wire logic              scan_step_clock,
	input  wire logic              keystrokeStrobe,
	input  wire logic              primaryForceSpace,
	input  wire logic              secondaryForceMark,
	input  wire logic              clear_request,
	input  wire logic              keys_enabled_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////
	sequence sLocked;
		!keys_enabled_flag ##1 !keys_enabled_flag;
	endsequence
	sequence sClear;
		clearKey && shiftKey;
	endsequence
	////////////////////////////////////////
	AST_STEP: assert property (scan_step_clock |=>
		scan_code_bits == $past(scan_code_bits) + 7'h01)
		else $error("scan counter did not step");
	AST_HOLD: assert property (!keyMatch_n |=>
		$stable(scan_code_bits)) else $error("held code moved");
	AST_GATE: assert property (scan_step_clock ==
		(char_rate_tick && keyMatch_n)) else $error("step gate wrong");
	AST_SPACE: assert property (primaryForceSpace ==
		(breakKey && transmitting)) else $error("space force wrong");
	AST_MARK: assert property (secondaryForceMark ==
		(breakKey && !transmitting && secondaryMode))
		else $error("mark force wrong");
	AST_CLEAR: assert property (clear_request ==
		(clearKey && shiftKey)) else $error("clear request wrong");
	AST_REENABLE: assert property (sClear |=> keys_enabled_flag)
		else $error("clear did not enable keys");
	AST_LOCKED: assert property (sLocked |-> !keystrokeStrobe)
		else $error("strobe while locked");
	AST_PULSE: assert property (keystrokeStrobe |=> !keystrokeStrobe)
		else $error("strobe longer than one cycle");
	AST_RDZERO: assert property (!$past(regRd) |-> regRdData == '0)
		else $error("read data outside read slot");
endmodule
bind kse_keyboard_encoder kse_checker chk (.*);

// [sim/testbench.sv]
// self-checking bench for the keyboard scan encoder
module testbench
	import kse_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, rst_b = 0, char_rate_tick = 0, row_rate_tick = 0;
	logic line_rate_pulse = 0, repeat_key = 0, ctrlKey = 0, shiftKey = 0;
	logic upperCaseKey = 0, breakKey = 0, clearKey = 0, identify_key = 0;
	logic tx_holding_empty = 1, transmitting = 0, secondaryMode = 0;
	logic command_execute_window = 0, lockCmd = 0, unlockCmd = 0;
	logic enqCmd = 0, regWr = 0, regRd = 0, keyDown = 0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0, regRdData;
	logic [6:0] keyCode = 7'h00, scan_code_bits, txCode;
	logic [1:0] div = 2'h0;
	wire logic keyMatch_n;
	logic scan_step_clock, keystrokeStrobe, primaryForceSpace;
	logic secondaryForceMark, clear_request, keys_enabled_flag;
	int fail_count = 0, cmp_count = 0, sc = 0;
	kse_keyboard_encoder dut (.*);
	kse_key_array keys (.scan_code_bits(scan_code_bits), .keyDown(keyDown),
		.keyCode(keyCode), .keyMatch_n(keyMatch_n));
	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		div <= div + 2'h1;
		char_rate_tick <= div == 2'h3;
		if (keystrokeStrobe === 1'b1)
			sc <= sc + 1;
	end
	////////////////////////////////////////
	task automatic ck(string n, logic [31:0] s, logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tk(input bit l, input int n);
		repeat (n)
		begin
			@(posedge core_clk);
			if (l)
				line_rate_pulse <= 1'b1;
			else
				row_rate_tick <= 1'b1;
			@(posedge core_clk);
			line_rate_pulse <= 1'b0;
			row_rate_tick <= 1'b0;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge core_clk) regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk) regRd <= 1'b0;
		@(negedge core_clk) v = regRdData;
	endtask
	task automatic waitS(output logic g);
		g = 0;
		for (int i = 0; i < 800 && !g; i++)
			@(negedge core_clk) g = keystrokeStrobe === 1'b1;
	endtask
	task automatic hit(input logic [6:0] c, input logic [2:0] m,
		output logic g);
		@(posedge core_clk);
		keyCode <= c;
		{upperCaseKey, shiftKey, ctrlKey} <= m;
		keyDown <= 1'b1;
		waitS(g);
	endtask
	task automatic up;
		@(posedge core_clk) keyDown <= 1'b0;
		tk(0, 5);
	endtask
	task automatic cmd(input logic [1:0] v, input logic w);
		@(posedge core_clk);
		{lockCmd, unlockCmd} <= v;
		command_execute_window <= w;
		@(posedge core_clk);
		{lockCmd, unlockCmd} <= 2'h0;
		command_execute_window <= 1'b0;
		@(negedge core_clk);
	endtask
	function automatic logic [6:0] mc(logic [6:0] c, logic [2:0] m);
		logic [6:0] r;
		r = c;
		if (m[1] && c[6])
			r[5] = ~r[5];
		if (m[1] && c[6:4] == COL_THREE && c[3:0] != ROW_ZERO)
			r[4] = 1'b0;
		if (m[2] && c[6:5] == 2'h3)
			r[5] = 1'b0;
		if (m[0])
			r[6:5] = 2'h0;
		return r;
	endfunction
	task close_out;
		if (fail_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////
	initial
	begin
		repeat (90000) @(posedge core_clk);
		fail_count++;
		close_out;
	end
	initial
	begin
		logic g;
		logic [6:0] c, s0;
		logic [2:0] m;
		logic [31:0] v;
		logic [9:0] tbl [8];
		int n;
		tbl = '{10'h0B2, 10'h161, 10'h131, 10'h130, 10'h120, 10'h262,
			10'h371, 10'h140};
		n = $urandom(32'h4f5eb370);
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		rd(REG_CONTROL, v);
		ck("control", v, 32'h0);
		rd(REG_MSG_LEN, v);
		ck("msg_len", v, 32'h0);
		rd(8'h0C, v);
		ck("unmapped", v, 32'h0);
		wr(REG_MSG_LEN, 32'h20);
		rd(REG_MSG_LEN, v);
		ck("msg_len", v, 32'h20);
		@(negedge core_clk) s0 = scan_code_bits;
		n = 0;
		repeat (40) @(posedge core_clk) n += char_rate_tick;
		@(negedge core_clk) ck("scan", scan_code_bits, 7'(s0 + n));
		for (int k = 0; k < 28; k++)
		begin
			c = k < 8 ? tbl[k][6:0] : 7'($urandom);
			m = k < 8 ? tbl[k][9:7] : 3'($urandom);
			@(posedge core_clk);
			{breakKey, transmitting, secondaryMode} <= 3'($urandom);
			hit(c, m, g);
			ck("strobe", g, 1);
			ck("held", scan_code_bits, c);
			ck("code", txCode, mc(c, m));
			rd(REG_STATUS, v);
			ck("status", v, {17'h0, c, 8'h09});
			tk(0, 5);
			@(posedge core_clk) keyDown <= 1'b0;
		end
		hit(7'h41, 3'h0, g);
		@(posedge core_clk) keyDown <= 1'b0;
		tk(0, 4);
		hit(7'h41, 3'h0, g);
		ck("bounce", g, 0);
		@(posedge core_clk) keyDown <= 1'b0;
		tk(0, 1);
		hit(7'h41, 3'h0, g);
		ck("rematch", g, 1);
		tk(0, 5);
		@(posedge core_clk) repeat_key <= 1'b1;
		tx_holding_empty <= 1'b0;
		n = sc;
		tk(1, 5);
		repeat (4) @(negedge core_clk);
		ck("repeat_held", sc - n, 0);
		@(posedge core_clk) tx_holding_empty <= 1'b1;
		repeat (4) @(negedge core_clk);
		ck("repeat_go", sc - n, 1);
		tk(1, 10);
		repeat (4) @(negedge core_clk);
		ck("repeat_rate", sc - n, 3);
		@(posedge core_clk) repeat_key <= 1'b0;
		up;
		cmd(2'h2, 1'b0);
		ck("window", keys_enabled_flag, 1);
		cmd(2'h2, 1'b1);
		ck("locked", keys_enabled_flag, 0);
		hit(7'h35, 3'h0, g);
		ck("lock_strobe", g, 0);
		up;
		cmd(2'h1, 1'b1);
		ck("unlock", keys_enabled_flag, 1);
		cmd(2'h2, 1'b1);
		@(posedge core_clk) {clearKey, shiftKey} <= 2'h3;
		@(posedge core_clk) {clearKey, shiftKey} <= 2'h0;
		@(negedge core_clk) ck("clear", keys_enabled_flag, 1);
		wr(REG_CONTROL, 32'h1);
		cmd(2'h2, 1'b1);
		ck("hold", keys_enabled_flag, 1);
		wr(REG_MSG_BASE, 32'h55);
		rd(REG_MSG_BASE, v);
		ck("msg", v, 32'h55);
		wr(REG_MSG_LEN, 32'h1);
		wr(REG_CONTROL, 32'h2);
		@(posedge core_clk) identify_key <= 1'b1;
		@(posedge core_clk) identify_key <= 1'b0;
		waitS(g);
		ck("ident", txCode, 7'h55);
		@(posedge core_clk);
		@(posedge core_clk);
		enqCmd <= 1'b1;
		command_execute_window <= 1'b1;
		@(posedge core_clk);
		enqCmd <= 1'b0;
		command_execute_window <= 1'b0;
		waitS(g);
		ck("enq", g, 1);
		wr(REG_CONTROL, 32'h0);
		close_out;
	end
endmodule
